// ### shared/encoder_pulse_divider_pkg.sv
/*
 * constants shared by the encoder pulse divider: switch field layout,
 * register offsets, reset values and field positions of the register map.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package encoder_pulse_divider_pkg;
    // switch bank layout (index into divider_setting_switch)
    localparam int          SW_WIDTH       = 7;
    localparam int          SW_FACTOR_LSB  = 0;
    localparam int          SW_FACTOR_W    = 5;
    localparam int          SW_OTYPE_BIT   = 5;
    localparam int          SW_CLEAR_BIT   = 6;

    // register byte offsets
    localparam logic [11:0] CTRL_OFFSET    = 12'h000;
    localparam logic [11:0] STATUS_OFFSET  = 12'h004;

    // control register fields
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_CLR_BIT   = 1;
    localparam logic        CTRL_EN_RESET  = 1'b1;
    localparam logic        CTRL_CLR_RESET = 1'b0;

    // status register fields
    localparam int          STAT_FACTOR_LSB = 0;
    localparam int          STAT_OTYPE_BIT  = 5;
    localparam int          STAT_CLEAR_BIT  = 6;
    localparam int          STAT_DIR_BIT    = 7;
    localparam int          STAT_A_BIT      = 8;
    localparam int          STAT_B_BIT      = 9;

    // output type selection
    typedef enum logic {OTYPE_PULSES, OTYPE_DIRECTION} otype_t;

    localparam logic [4:0]  FACTOR_RESET   = 5'h01;
endpackage : encoder_pulse_divider_pkg
`default_nettype wire

// ### hdl/edge_divider.sv
/*
 * one phase of the divider: counts both edges of a synchronised phase and
 * toggles its output every n edges, so the output period is n input periods.
 * assumes edge_p is a one-cycle pulse on pclk and factor is at least 1.
 */
`timescale 1ns/1ps
`default_nettype none
module edge_divider
    import encoder_pulse_divider_pkg::*;
#(
    parameter int FACTOR_W = 5
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                clear,
    input  wire logic                edge_p,
    input  wire logic [FACTOR_W-1:0] factor,
    output logic                     div_out
);
    logic [FACTOR_W-1:0] cnt_q;

    // counting both edges lets odd factors give an exact period of n cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q   <= '0;
            div_out <= 1'b0;
        end else if (clear) begin
            cnt_q   <= '0;
            div_out <= 1'b0;
        end else if (edge_p) begin
            // >= guards against a factor lowered without a clear
            if (cnt_q >= factor - FACTOR_W'(1)) begin
                cnt_q   <= '0;
                div_out <= ~div_out;
            end else begin
                cnt_q <= cnt_q + FACTOR_W'(1);
            end
        end
    end
endmodule : edge_divider
`default_nettype wire

// ### hdl/encoder_pulse_divider.sv
/*
 * encoder pulse divider: synchronises quadrature inputs and switch bank,
 * divides both phases by n, optionally replaces phase b by direction, and
 * offers control and status over apb.
 * assumes a static switch bank and encoder phases asynchronous to pclk.
 */
// Implementation choices: the APB register port and the placing of the registers.
// What this block does
// - output frequency equals input frequency divided by factor n
// - any factor from 1 to 31 is accepted and applied
// - factor comes from switch field bits 0 to 4, bit 0 lowest
// - a switch that is on reads as 0, off reads as 1
// - output type 0: divided a and b on line and open-collector pins
// - output type 1: phase b pins carry direction, phase a stays divided
// - direction low when a leads b, high when b leads a
`timescale 1ns/1ps
`default_nettype none
module encoder_pulse_divider
    import encoder_pulse_divider_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire logic                phase_a_in,
    input  wire logic                phase_b_in,
    input  wire logic [SW_WIDTH-1:0] divider_setting_switch,
    output logic                     line_a_out_p,
    output logic                     line_a_out_n,
    output logic                     line_b_out_p,
    output logic                     line_b_out_n,
    output logic                     open_collector_a_out,
    output logic                     open_collector_a_oe,
    output logic                     open_collector_b_out,
    output logic                     open_collector_b_oe
);
    logic [1:0]          ph_s1_q, ph_s2_q, ph_prev_q;
    logic [SW_WIDTH-1:0] sw_s1_q, sw_s2_q;
    logic [4:0]          factor_q;
    logic                otype_q;
    logic                clear_q;
    logic                dir_q;
    logic                ctrl_en_q, ctrl_clr_q;
    logic [1:0]          edge_p;
    logic [1:0]          div_q;
    logic                clear_all;
    logic                b_sel;
    logic [SW_WIDTH-1:0] sw_logic;

    // two flops before anything looks at a pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_s1_q   <= 2'h0;
            ph_s2_q   <= 2'h0;
            ph_prev_q <= 2'h0;
        end else begin
            ph_s1_q   <= {phase_b_in, phase_a_in};
            ph_s2_q   <= ph_s1_q;
            ph_prev_q <= ph_s2_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_s1_q <= '0;
            sw_s2_q <= '0;
        end else begin
            sw_s1_q <= divider_setting_switch;
            sw_s2_q <= sw_s1_q;
        end
    end

    assign edge_p   = ph_s2_q ^ ph_prev_q;
    // pin high means the switch is on, which is logic 0
    assign sw_logic = ~sw_s2_q;

    // factor 0 is not a valid setting; it is run as 1 rather than stalling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            factor_q <= FACTOR_RESET;
            otype_q  <= 1'b0;
            clear_q  <= 1'b1;
        end else begin
            factor_q <= (sw_logic[SW_FACTOR_LSB +: SW_FACTOR_W] == 5'h00) ? 5'h01
                      : sw_logic[SW_FACTOR_LSB +: SW_FACTOR_W];
            otype_q  <= sw_logic[SW_OTYPE_BIT];
            clear_q  <= ~sw_logic[SW_CLEAR_BIT];  // clear while the bit is 0
        end
    end

    assign clear_all = clear_q | ctrl_clr_q;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_phase
            edge_divider #(.FACTOR_W(SW_FACTOR_W)) u_div (
                .pclk    (pclk),
                .presetn (presetn),
                .clear   (clear_all),
                .edge_p  (edge_p[gi]),
                .factor  (factor_q),
                .div_out (div_q[gi])
            );
        end
    endgenerate

    // each phase sampled at each edge of the other tells the order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= 1'b0;
        end else if (edge_p[0]) begin
            dir_q <= ph_s2_q[1] ^ ~ph_s2_q[0];
        end else if (edge_p[1]) begin
            dir_q <= ph_s2_q[0] ^ ph_s2_q[1];
        end
    end

    assign b_sel = (otype_q == OTYPE_DIRECTION) ? dir_q : div_q[1];

    // disabled outputs rest at level 0, n lines and open-collector enables high; open collector pulls low when level is 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_a_out_p         <= 1'b0;
            line_a_out_n         <= 1'b1;
            line_b_out_p         <= 1'b0;
            line_b_out_n         <= 1'b1;
            open_collector_a_out <= 1'b0;
            open_collector_a_oe  <= 1'b1;
            open_collector_b_out <= 1'b0;
            open_collector_b_oe  <= 1'b1;
        end else begin
            line_a_out_p         <= ctrl_en_q & div_q[0];
            line_a_out_n         <= ~(ctrl_en_q & div_q[0]);
            line_b_out_p         <= ctrl_en_q & b_sel;
            line_b_out_n         <= ~(ctrl_en_q & b_sel);
            open_collector_a_out <= ctrl_en_q & div_q[0];
            open_collector_a_oe  <= ~(ctrl_en_q & div_q[0]);
            open_collector_b_out <= ctrl_en_q & b_sel;
            open_collector_b_oe  <= ~(ctrl_en_q & b_sel);
        end
    end

    // apb slave: no wait state; read data is put into a flop during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (paddr == CTRL_OFFSET) begin
                if (!pwrite) begin
                    prdata[CTRL_EN_BIT]  <= ctrl_en_q;
                    prdata[CTRL_CLR_BIT] <= ctrl_clr_q;
                end
            end else if (paddr == STATUS_OFFSET) begin
                if (!pwrite) begin
                    prdata[STAT_FACTOR_LSB +: 5] <= factor_q;
                    prdata[STAT_OTYPE_BIT]       <= otype_q;
                    prdata[STAT_CLEAR_BIT]       <= clear_all;
                    prdata[STAT_DIR_BIT]         <= dir_q;
                    prdata[STAT_A_BIT]           <= div_q[0];
                    prdata[STAT_B_BIT]           <= div_q[1];
                end
            end else begin
                pslverr <= 1'b1;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_q  <= CTRL_EN_RESET;
            ctrl_clr_q <= CTRL_CLR_RESET;
        end else if (psel && penable && pready && pwrite && paddr == CTRL_OFFSET) begin
            ctrl_en_q  <= pwdata[CTRL_EN_BIT];
            ctrl_clr_q <= pwdata[CTRL_CLR_BIT];
        end
    end

    // helper: edges of phase a seen since the last toggle of its divider
    logic [5:0] a_edges_q;
    logic       div_a_last_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_edges_q    <= 6'h00;
            div_a_last_q <= 1'b0;
        end else begin
            div_a_last_q <= div_q[0];
            if (clear_all || (div_q[0] != div_a_last_q)) begin
                a_edges_q <= {5'h00, edge_p[0] & ~clear_all};
            end else if (edge_p[0]) begin
                a_edges_q <= a_edges_q + 6'h01;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence a_rise_b_low_s;
        edge_p[0] && ph_s2_q[0] && !ph_s2_q[1];
    endsequence
    sequence a_rise_b_high_s;
        edge_p[0] && ph_s2_q[0] && ph_s2_q[1];
    endsequence

    AST_DIV_PERIOD: assert property (
        $changed(div_q[0]) && !$past(clear_all) && $stable(factor_q)
            |-> $past(a_edges_q) + 6'h01 >= {1'b0, factor_q})
        else $error("divider toggled before n edges");
    AST_FACTOR_NONZERO: assert property (factor_q >= 5'h01 && factor_q <= 5'h1F)
        else $error("factor out of range");
    AST_FACTOR_FIELD: assert property (
        ##1 ($past(~sw_s2_q[4:0]) != 5'h00) |-> factor_q == $past(~sw_s2_q[4:0]))
        else $error("factor does not follow switch bits 0 to 4");
    AST_SWITCH_ON_CLEARS: assert property (
        sw_s2_q[SW_CLEAR_BIT] |=> clear_q ##1 (div_q == 2'b00))
        else $error("switch on did not clear the divider");
    AST_PULSE_MODE_B: assert property (
        (otype_q == OTYPE_PULSES) && ctrl_en_q
            |=> line_b_out_p == $past(div_q[1]) && open_collector_b_out == line_b_out_p)
        else $error("phase b pins do not carry divided pulses");
    AST_DIR_MODE_B: assert property (
        (otype_q == OTYPE_DIRECTION) && ctrl_en_q
            |=> line_b_out_p == $past(dir_q) && line_a_out_p == $past(div_q[0]))
        else $error("direction mode output wrong");
    AST_A_LEADS: assert property (a_rise_b_low_s |=> !dir_q)
        else $error("a leading b not shown as low");
    AST_B_LEADS: assert property (a_rise_b_high_s |=> dir_q ##1 (line_b_out_p
        || !$past(ctrl_en_q) || $past(otype_q) != OTYPE_DIRECTION || $past(edge_p[0])))
        else $error("b leading a not shown as high");
    AST_LINE_PAIR: assert property (line_a_out_n == !line_a_out_p
        && line_b_out_n == !line_b_out_p)
        else $error("line pair not complementary");
endmodule : encoder_pulse_divider
`default_nettype wire

// ### test/encoder_model.sv
/*
 * quadrature encoder model: on a start pulse it walks the given number of
 * quarter steps forward (a leads b) or backward, one step per period.
 * assumes a free running pclk; phase b is a registered level, phase a is decoded from the registered state.
 */
`timescale 1ns/1ps
`default_nettype none
module encoder_model #(
    parameter int STEP_CYCLES = 5
) (
    input  wire logic       pclk,
    input  wire logic       start,
    input  wire logic       reverse,
    input  wire logic [7:0] steps,
    output logic            phase_a,
    output logic            phase_b,
    output logic            busy
);
    logic [1:0] state_q = 2'h0;
    logic [7:0] left_q  = 8'h00;
    logic [7:0] wait_q  = 8'h00;
    logic       dir_q   = 1'b0;
    logic       busy_q  = 1'b0;
    assign busy = busy_q;
    // gray order 00,10,11,01 so only one phase moves per step
    assign phase_a = state_q[0] ^ state_q[1];
    assign phase_b = state_q[1];
    always @(posedge pclk) begin
        if (start) begin
            busy_q <= 1'b1;
            left_q <= steps;
            wait_q <= 8'(STEP_CYCLES);
            dir_q  <= reverse;
        end else if (busy_q) begin
            if (wait_q != 8'h00) begin
                wait_q <= wait_q - 8'h01;
            end else if (left_q == 8'h00) begin
                busy_q <= 1'b0;
            end else begin
                state_q <= dir_q ? state_q - 2'h1 : state_q + 2'h1;
                left_q  <= left_q - 8'h01;
                wait_q  <= 8'(STEP_CYCLES);
            end
        end
    end
endmodule : encoder_model
`default_nettype wire

// ### test/encoder_pulse_divider_bench.sv
/*
 * self-checking bench: apb tasks, switch bank stimulus and encoder runs,
 * counting output toggles against the selected factor.
 * assumes the encoder model and the design package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module encoder_pulse_divider_bench
    import encoder_pulse_divider_pkg::*;
;
    logic               pclk = 1'b0, presetn = 1'b0;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0, prdata, rd;
    logic               pready, pslverr, err, pa, pb, busy;
    logic [SW_WIDTH-1:0] divider_setting_switch = '0;
    logic               la_p, la_n, lb_p, lb_n, oa, oa_oe, ob, ob_oe;
    logic               start = 1'b0, rev = 1'b0, last_a, last_b;
    logic [7:0]         steps = 8'h00;
    int                 n_errors = 0, check_count = 0, tog_a = 0, tog_b = 0, base_a, base_b;
    int                 factors[5] = '{1, 2, 5, 13, 31};

    encoder_model enc (.pclk(pclk), .start(start), .reverse(rev), .steps(steps),
                       .phase_a(pa), .phase_b(pb), .busy(busy));
    encoder_pulse_divider dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .phase_a_in(pa), .phase_b_in(pb),
        .divider_setting_switch(divider_setting_switch), .line_a_out_p(la_p),
        .line_a_out_n(la_n), .line_b_out_p(lb_p), .line_b_out_n(lb_n),
        .open_collector_a_out(oa), .open_collector_a_oe(oa_oe),
        .open_collector_b_out(ob), .open_collector_b_oe(ob_oe));

    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (la_p !== last_a) tog_a++;
        if (lb_p !== last_b) tog_b++;
        last_a = la_p;
        last_b = lb_p;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // waits for pready as long as it takes; only the watchdog ends a dead bus
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // pin high means switch on, which reads as logic 0
    task automatic set_sw(input logic [4:0] n, input logic ot, input logic clr);
        @(posedge pclk);
        divider_setting_switch <= ~{~clr, ot, n};
        repeat (8) @(posedge pclk);
    endtask : set_sw

    task automatic prog(input logic [4:0] n, input logic ot);
        set_sw(n, ot, 1'b1);
        set_sw(n, ot, 1'b0);
    endtask : prog

    // a stuck encoder is caught by the watchdog, not by a local limit
    task automatic run(input logic r);
        @(negedge pclk);
        base_a = tog_a;
        base_b = tog_b;
        @(posedge pclk);
        start <= 1'b1;
        rev   <= r;
        steps <= 8'd124;
        @(posedge pclk);
        start <= 1'b0;
        do begin
            @(posedge pclk);
        end while (busy !== 1'b0);
        repeat (8) @(posedge pclk);
        @(negedge pclk);
    endtask : run

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (50000) @(posedge pclk);
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, 12'h00C, 32'h2);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        foreach (factors[i]) begin
            prog(5'(factors[i]), 1'b0);
            apb(1'b0, STATUS_OFFSET, 32'h0);
            check(rd[5:0], {26'h0, 1'b0, 5'(factors[i])});
            run(1'b0);
            check(tog_a - base_a, 62 / factors[i]);
            check(tog_b - base_b, 62 / factors[i]);
            check({la_n, oa, oa_oe, lb_n, ob, ob_oe},
                  {~la_p, la_p, ~la_p, ~lb_p, lb_p, ~lb_p});
        end
        prog(5'd1, 1'b1);
        run(1'b0);
        check(tog_a - base_a, 62);
        check(tog_b - base_b, 0);
        check({lb_p, ob, lb_n, ob_oe}, 4'b0011);
        run(1'b1);
        check({lb_p, ob, lb_n, ob_oe}, 4'b1100);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check(rd[7:5], 3'b101);
        prog(5'd1, 1'b0);
        apb(1'b1, CTRL_OFFSET, 32'h3);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h3);
        run(1'b0);
        check(tog_a - base_a, 0);
        complete_run();
    end
endmodule : encoder_pulse_divider_bench
`default_nettype wire
